/* design/eat_top.sv */
// Two-wire access to the 256-byte nonvolatile array
//
// Contract
// R1 - Master opens with START and the bus address, direction bit zero.
// R2 - Device acknowledges address, command, memory address and each written byte.
// R3 - Master sends the memory-access command after the address acknowledge.
// R4 - Master then sends one byte giving the start location.
// R5 - Master writes any number of bytes MSB first, then STOP.
// R6 - Only the last eight bytes are kept, wrapping inside an eight-byte page.
// R7 - STOP after a write starts programming of the buffered bytes.
// R8 - START instead of STOP abandons the write and drops the buffer.
// R9 - Programming finishes typically in 10 ms, at most 50 ms.
// R10 - While programming, the command byte of a new transaction is not acknowledged.
// R11 - Master retries the whole transaction from START until acknowledged.
// R12 - For reads, master sends repeated START and the address with direction one.
// R13 - Device sends stored bytes MSB first from the start location.
// R14 - Master acknowledges wanted bytes, answers the last with no-acknowledge, then STOP.
// R15 - Read pointer advances by one after each byte sent.
// R16 - Array holds 256 bytes, so the start location is a full byte.
// R17 - Read pointer rolls over from the top location to zero.
`timescale 1ns/1ns
module eat_top #(
   parameter logic [6:0] DEV_ADDR = eat_pkg::DEV_ADDR_DEFAULT,
   parameter int PROG_CYCLES = eat_pkg::PROG_TYP_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_o,
   output logic sda_oe,
   output logic prog_busy
);

   // Link-side state, clocked by the bus clock and the data line
   logic start_tgl_reg;
   logic stop_tgl_reg;
   logic start_seen_reg;
   logic start_seen_next;
   logic start_pend;
   logic [7:0] rx_reg;
   eat_pkg::eat_link_t lstate_reg;
   eat_pkg::eat_link_t lstate_next;
   logic [3:0] bit_reg;
   logic [3:0] bit_next;
   logic [eat_pkg::ADDR_W-1:0] ptr_reg;
   logic [eat_pkg::ADDR_W-1:0] ptr_next;
   logic [eat_pkg::PAGE_W-1:0] page_reg;
   logic [eat_pkg::PAGE_W-1:0] page_next;
   logic [eat_pkg::SLOT_W-1:0] slot_reg;
   logic [eat_pkg::SLOT_W-1:0] slot_next;
   logic [eat_pkg::PAGE_BYTES-1:0] mask_reg;
   logic [eat_pkg::PAGE_BYTES-1:0] mask_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic oe_reg;
   logic oe_next;
   logic buf_we;
   logic rd_load;
   logic byte_done;
   logic addr_hit;
   logic busy_l;
   logic [7:0] buf_reg [eat_pkg::PAGE_BYTES];

   // System-side state
   logic [7:0] mem_reg [eat_pkg::MEM_BYTES];
   logic [7:0] rd_byte;
   logic stop_s;
   logic stop_prev_reg;
   logic stop_evt;
   logic commit;
   logic busy;

   // START and STOP are data edges while the bus clock is high; the bus
   // clock may stand still around them, so the data line clocks these.
   always_ff @(negedge sda_in or negedge rstn) begin
      if (!rstn) begin
         start_tgl_reg <= 1'b0;
      end else if (scl_in) begin
         start_tgl_reg <= ~start_tgl_reg;
      end
   end

   always_ff @(posedge sda_in or negedge rstn) begin
      if (!rstn) begin
         stop_tgl_reg <= 1'b0;
      end else if (scl_in) begin
         stop_tgl_reg <= ~stop_tgl_reg;
      end
   end

   // Data is stable while the bus clock is high
   always_ff @(posedge scl_in or negedge rstn) begin
      if (!rstn) begin
         rx_reg <= 8'h00;
      end else begin
         rx_reg <= {rx_reg[6:0], sda_in};
      end
   end

   // Busy level into the link domain; it settles during the address byte
   eat_sync #(
      .W(1)
   ) u_busy_sync (
      .clk(scl_in),
      .rstn(rstn),
      .d(busy),
      .q(busy_l)
   );

   // Toggle settled since the START edge, one bus-clock phase earlier
   assign start_pend = start_tgl_reg ^ start_seen_reg;
   assign byte_done = (bit_reg == eat_pkg::BIT_LAST);
   assign addr_hit = (rx_reg[7:1] == DEV_ADDR);
   // Array is only written during programming, so this read is quasi-static
   assign rd_byte = mem_reg[ptr_reg];

   always_comb begin
      start_seen_next = start_tgl_reg;
      lstate_next = lstate_reg;
      bit_next = bit_reg;
      ptr_next = ptr_reg;
      page_next = page_reg;
      slot_next = slot_reg;
      mask_next = mask_reg;
      tx_next = tx_reg;
      oe_next = 1'b0;
      buf_we = 1'b0;
      rd_load = 1'b0;
      if (start_pend) begin
         // Any START drops the staged bytes; a STOP has committed them already
         lstate_next = eat_pkg::L_ADDR; // [R8]
         bit_next = eat_pkg::BIT_FIRST;
         mask_next = '0; // [R8]
      end else if (lstate_reg != eat_pkg::L_IDLE) begin
         if (byte_done) begin
            bit_next = eat_pkg::BIT_ACK;
            unique case (lstate_reg)
               eat_pkg::L_ADDR: begin
                  if (addr_hit) begin
                     oe_next = 1'b1; // [R2]
                     lstate_next = rx_reg[0] ? eat_pkg::L_RDATA : eat_pkg::L_CMD;
                  end else begin
                     lstate_next = eat_pkg::L_IDLE;
                  end
               end
               eat_pkg::L_CMD: begin
                  if ((rx_reg == eat_pkg::CMD_MEM_ACCESS) && !busy_l) begin
                     oe_next = 1'b1; // [R2]
                     lstate_next = eat_pkg::L_MADR;
                  end else begin
                     // Refused while programming, or an unserved command
                     lstate_next = eat_pkg::L_IDLE; // [R10]
                  end
               end
               eat_pkg::L_MADR: begin
                  oe_next = 1'b1; // [R2]
                  ptr_next = rx_reg; // [R16]
                  page_next = rx_reg[7:eat_pkg::SLOT_W];
                  slot_next = rx_reg[eat_pkg::SLOT_W-1:0];
                  lstate_next = eat_pkg::L_WDATA;
               end
               eat_pkg::L_WDATA: begin
                  oe_next = 1'b1; // [R2]
                  buf_we = 1'b1;
                  mask_next = mask_reg | (8'h01 << slot_reg); // [R6]
                  slot_next = slot_reg + 3'h1; // [R6]
               end
               eat_pkg::L_RDATA: begin
                  // Release the line for the master's answer
                  oe_next = 1'b0;
               end
               eat_pkg::L_IDLE: begin
                  lstate_next = eat_pkg::L_IDLE;
               end
            endcase
         end else if (bit_reg == eat_pkg::BIT_ACK) begin
            bit_next = eat_pkg::BIT_FIRST;
            // Our own address acknowledge also samples as zero here
            if (lstate_reg == eat_pkg::L_RDATA) begin
               if (!rx_reg[0]) begin
                  rd_load = 1'b1;
                  oe_next = ~rd_byte[7]; // [R13]
                  tx_next = {rd_byte[6:0], 1'b0};
                  ptr_next = ptr_reg + 8'h01; // [R15] [R17]
               end else begin
                  lstate_next = eat_pkg::L_IDLE;
               end
            end
         end else begin
            bit_next = bit_reg + 4'h1;
            if (lstate_reg == eat_pkg::L_RDATA) begin
               oe_next = ~tx_reg[7]; // [R13]
               tx_next = {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

   // Link state changes while the bus clock is low
   always_ff @(negedge scl_in or negedge rstn) begin
      if (!rstn) begin
         start_seen_reg <= 1'b0;
         lstate_reg <= eat_pkg::L_IDLE;
         bit_reg <= eat_pkg::BIT_FIRST;
         ptr_reg <= '0;
         page_reg <= '0;
         slot_reg <= '0;
         mask_reg <= '0;
         tx_reg <= 8'h00;
         oe_reg <= 1'b0;
      end else begin
         start_seen_reg <= start_seen_next;
         lstate_reg <= lstate_next;
         bit_reg <= bit_next;
         ptr_reg <= ptr_next;
         page_reg <= page_next;
         slot_reg <= slot_next;
         mask_reg <= mask_next;
         tx_reg <= tx_next;
         oe_reg <= oe_next;
      end
   end

   // Staging buffer; no reset needed, the mask says which slots are live
   always_ff @(negedge scl_in) begin
      if (buf_we) begin
         buf_reg[slot_reg] <= rx_reg; // [R6]
      end
   end

   // Open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe = oe_reg;

   // STOP event into the system domain
   eat_sync #(
      .W(1)
   ) u_stop_sync (
      .clk(clk),
      .rstn(rstn),
      .d(stop_tgl_reg),
      .q(stop_s)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stop_prev_reg <= 1'b0;
      end else begin
         stop_prev_reg <= stop_s;
      end
   end

   assign stop_evt = stop_s ^ stop_prev_reg;
   // Mask and buffer hold still from STOP until the next START
   assign commit = stop_evt && (mask_reg != '0) && !busy; // [R7]

   eat_prog_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .start(commit),
      .busy(busy)
   );

   assign prog_busy = busy;

   // Masked bytes of the page written at once, timer then models the cell time
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < eat_pkg::MEM_BYTES; i++) begin
            mem_reg[i] <= eat_pkg::MEM_RESET;
         end
      end else if (commit) begin
         for (int i = 0; i < eat_pkg::PAGE_BYTES; i++) begin
            if (mask_reg[i]) begin
               mem_reg[{page_reg, eat_pkg::SLOT_W'(i)}] <= buf_reg[i]; // [R7]
            end
         end
      end
   end

   property p_addr_ack;
      @(negedge scl_in) disable iff (!rstn)
      (!start_pend && (lstate_reg == eat_pkg::L_ADDR) && byte_done && addr_hit) |=> oe_reg;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged"); // [R2]

   property p_write_ack_release;
      @(negedge scl_in) disable iff (!rstn)
      (!start_pend && (lstate_reg == eat_pkg::L_WDATA) && byte_done) |=> oe_reg ##1 (start_pend || !oe_reg);
   endproperty
   a_write_ack_release: assert property (p_write_ack_release) else $error("data ack wrong"); // [R2]

   property p_cmd_refused;
      @(negedge scl_in) disable iff (!rstn)
      (!start_pend && (lstate_reg == eat_pkg::L_CMD) && byte_done && busy_l)
         |=> (!oe_reg && (lstate_reg == eat_pkg::L_IDLE));
   endproperty
   a_cmd_refused: assert property (p_cmd_refused) else $error("command acked while busy"); // [R10]

   property p_wrap;
      @(negedge scl_in) disable iff (!rstn)
      buf_we |=> ((slot_reg == 3'($past(slot_reg) + 3'h1)) && (mask_reg[$past(slot_reg)]));
   endproperty
   a_wrap: assert property (p_wrap) else $error("write slot did not wrap in page"); // [R6]

   property p_abort;
      @(negedge scl_in) disable iff (!rstn)
      start_pend |=> ((mask_reg == '0) && (lstate_reg == eat_pkg::L_ADDR));
   endproperty
   a_abort: assert property (p_abort) else $error("buffer kept after START"); // [R8]

   property p_read_msb;
      @(negedge scl_in) disable iff (!rstn)
      rd_load |=> (oe_reg == !$past(rd_byte[7])) ##1 (start_pend || (oe_reg == !$past(tx_reg[7])));
   endproperty
   a_read_msb: assert property (p_read_msb) else $error("read bits not MSB first"); // [R13]

   property p_read_incr;
      @(negedge scl_in) disable iff (!rstn)
      (rd_load && !start_pend) |=> (ptr_reg == 8'($past(ptr_reg) + 8'h01));
   endproperty
   a_read_incr: assert property (p_read_incr) else $error("read pointer did not advance"); // [R15]

   property p_read_roll;
      @(negedge scl_in) disable iff (!rstn)
      (rd_load && (ptr_reg == 8'hFF)) |=> (ptr_reg == 8'h00);
   endproperty
   a_read_roll: assert property (p_read_roll) else $error("read pointer did not roll over"); // [R17]

   property p_commit;
      @(posedge clk) disable iff (!rstn)
      (stop_evt && (mask_reg != '0) && !busy) |=> busy ##1 busy;
   endproperty
   a_commit: assert property (p_commit) else $error("STOP did not start programming"); // [R7]

endmodule : eat_top

/* shared/eat_pkg.sv */
// Constants and types for the two-wire nonvolatile memory access block
package eat_pkg;

   // System clock
   localparam int CLK_HZ = 20_000_000;

   // Programming cycle time, typical and longest, in milliseconds
   localparam int PROG_TYP_MS = 10;
   localparam int PROG_MAX_MS = 50;

   // Cycle counts derived from the clock rate
   localparam int PROG_TYP_CYCLES = PROG_TYP_MS * (CLK_HZ / 1000);
   localparam int PROG_MAX_CYCLES = PROG_MAX_MS * (CLK_HZ / 1000);

   // Bus address of the device, plain default
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h48;

   // Memory-access command code
   localparam logic [7:0] CMD_MEM_ACCESS = 8'h17;

   // Array and write-buffer geometry
   localparam int BYTE_W = 8;
   localparam int MEM_BYTES = 256;
   localparam int ADDR_W = 8;
   localparam int PAGE_BYTES = 8;
   localparam int SLOT_W = 3;
   localparam int PAGE_W = ADDR_W - SLOT_W;

   // Erased memory content after reset
   localparam logic [7:0] MEM_RESET = 8'hFF;

   // Bit counter positions within a byte frame
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   // Byte-level protocol state of the link
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_CMD = 3'b011,
      L_MADR = 3'b010,
      L_WDATA = 3'b110,
      L_RDATA = 3'b111
   } eat_link_t;

endpackage : eat_pkg

/* design/eat_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ns
module eat_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;

   // Async clear so the stage is defined even with a stopped clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end

   assign q = s2_reg;

endmodule : eat_sync

/* design/eat_prog_timer.sv */
// Programming cycle timer
`timescale 1ns/1ns
module eat_prog_timer #(
   parameter int CYCLES = eat_pkg::PROG_TYP_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   output logic busy
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [31:0] elapsed_reg;

   always_comb begin
      cnt_next = cnt_reg;
      if (start && (cnt_reg == '0)) begin
         cnt_next = LOAD;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign busy = (cnt_reg != '0);

   // Helper: cycles spent busy in the current cycle
   always_ff @(posedge clk) begin
      if (!rstn || !busy) begin
         elapsed_reg <= 32'h0;
      end else begin
         elapsed_reg <= elapsed_reg + 32'h1;
      end
   end

   property p_prog_bound;
      @(posedge clk) disable iff (!rstn)
      busy |-> (elapsed_reg < 32'(CYCLES));
   endproperty
   a_prog_bound: assert property (p_prog_bound) else $error("programming ran past its time"); // [R9]

   property p_prog_load;
      @(posedge clk) disable iff (!rstn)
      (start && !busy) |=> (busy && (cnt_reg == LOAD));
   endproperty
   a_prog_load: assert property (p_prog_load) else $error("programming did not start"); // [R9]

   property p_prog_end;
      @(posedge clk) disable iff (!rstn)
      (busy && (elapsed_reg == 32'(CYCLES - 1))) |=> !busy;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("programming did not end on time"); // [R9]

endmodule : eat_prog_timer

/* bench/eat_master.sv */
// Two-wire bus master model that drives the link side of the block
`timescale 1ns/1ns
module eat_master (
   output logic scl,
   output logic sda_m,
   input wire logic sda_in
);
   // Quarter of the 64 ns link clock period
   localparam int Q = 16;

   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   // Also serves as repeated START; clock parks high between frames
   task automatic start();
      sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask : start

   task automatic stop();
      sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask : stop

   // Data changes only while the clock is low
   task automatic bit_slot(input logic b, output logic s);
      sda_m = b;
      #Q scl = 1'b1;
      #Q s = sda_in;
      #Q scl = 1'b0;
      #Q;
   endtask : bit_slot

   // Released to the pull-up during the acknowledge slot
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
      bit_slot(1'b1, s);
      ack = ~s;
   endtask : wbyte

   task automatic rbyte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         d[i] = s;
      end
      bit_slot(~more, s);
   endtask : rbyte
endmodule : eat_master

/* bench/eat_tb_top.sv */
// Self-checking bench for the two-wire memory access block
`timescale 1ns/1ns
module eat_tb_top;
   localparam int PROG = 50;
   localparam logic [6:0] DEV = eat_pkg::DEV_ADDR_DEFAULT;
   typedef struct {logic [7:0] madr; int n; logic [7:0] base; logic [7:0] first;} eat_row_t;
   // Write start, byte count, first byte, expected byte at page start
   eat_row_t rows [4] = '{'{8'h00, 10, 8'h00, 8'h88}, '{8'h0D, 5, 8'hA0, 8'hD3},
                          '{8'hFE, 2, 8'h5A, 8'hFF}, '{8'h40, 8, 8'h10, 8'h10}};
   logic clk = 1'b0;
   logic rstn;
   logic scl;
   logic sda_m;
   logic sda_oe;
   logic sda_o;
   logic prog_busy;
   logic a;
   wire logic sda_in;
   logic [7:0] exp_mem [256];
   int mismatches = 0;
   int num_checks = 0;

   always #25 clk = ~clk;
   // Open-drain wire with pull-up: the device's level counts only while it drives
   assign sda_in = sda_m & (sda_oe ? sda_o : 1'b1);

   eat_master i_eat_master (.scl(scl), .sda_m(sda_m), .sda_in(sda_in));

   eat_top #(.DEV_ADDR(DEV), .PROG_CYCLES(PROG)) i_eat_top (
      .clk(clk),
      .rstn(rstn),
      .scl_in(scl),
      .sda_in(sda_in),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .prog_busy(prog_busy)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // Restarts from START while the command is refused
   task automatic open_at(input logic [7:0] madr);
      logic ack;
      logic c;
      int tries;
      tries = 0;
      c = 1'b0;
      while (!c && tries < 20) begin
         i_eat_master.start();
         i_eat_master.wbyte({DEV, 1'b0}, ack);
         check(ack, 1'b1);
         i_eat_master.wbyte(eat_pkg::CMD_MEM_ACCESS, c);
         if (!c) i_eat_master.stop();
         tries++;
      end
      if (!c) begin
         mismatches++;
         report_and_stop();
      end
      i_eat_master.wbyte(madr, ack);
      check(ack, 1'b1);
   endtask : open_at

   task automatic write_run(input logic [7:0] madr, input int n, input logic [7:0] base, input logic keep);
      logic ack;
      logic [7:0] d;
      open_at(madr);
      for (int i = 0; i < n; i++) begin
         d = base + 8'(i) * 8'h11;
         i_eat_master.wbyte(d, ack);
         check(ack, 1'b1);
         if (keep) exp_mem[{madr[7:3], madr[2:0] + 3'(i)}] = d;
      end
   endtask : write_run

   task automatic read_run(input logic [7:0] madr, input int n);
      logic ack;
      logic [7:0] d;
      open_at(madr);
      i_eat_master.start();
      i_eat_master.wbyte({DEV, 1'b1}, ack);
      check(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_eat_master.rbyte(i < n - 1, d);
         check(d, exp_mem[8'(madr + 8'(i))]);
      end
      i_eat_master.stop();
      repeat (8) @(negedge clk);
   endtask : read_run

   task automatic wait_prog();
      int k;
      k = 0;
      repeat (6) @(negedge clk);
      check(prog_busy, 1'b1);
      while (prog_busy !== 1'b0 && k < PROG + 8) begin
         @(negedge clk);
         k++;
      end
      check(k <= PROG, 1'b1);
      if (k > PROG) report_and_stop();
   endtask : wait_prog

   initial begin
      #4_000_000;
      mismatches++;
      report_and_stop();
   end

   initial begin
      // X to 0 gives the link-side flops the falling edge their clear needs
      rstn = 1'b0;
      for (int i = 0; i < 256; i++) exp_mem[i] = eat_pkg::MEM_RESET;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      check(sda_oe, 1'b0);
      check(prog_busy, 1'b0);
      read_run(8'hFE, 4);
      foreach (rows[r]) begin
         write_run(rows[r].madr, rows[r].n, rows[r].base, 1'b1);
         i_eat_master.stop();
         wait_prog();
         read_run({rows[r].madr[7:3], 3'h0}, 8);
         check(exp_mem[{rows[r].madr[7:3], 3'h0}], rows[r].first);
      end
      // Distinct bytes on both sides of the top location
      read_run(8'hFE, 4);
      // START in place of STOP drops the buffered bytes
      write_run(8'h80, 3, 8'h33, 1'b0);
      i_eat_master.start();
      i_eat_master.stop();
      repeat (8) @(negedge clk);
      check(prog_busy, 1'b0);
      read_run(8'h80, 3);
      // Command refused while programming, then retried
      write_run(8'h20, 1, 8'h77, 1'b1);
      i_eat_master.stop();
      repeat (6) @(negedge clk);
      i_eat_master.start();
      i_eat_master.wbyte({DEV, 1'b0}, a);
      check(a, 1'b1);
      i_eat_master.wbyte(eat_pkg::CMD_MEM_ACCESS, a);
      check(a, 1'b0);
      i_eat_master.stop();
      read_run(8'h1F, 3);
      // Foreign address and unknown command stay unanswered
      i_eat_master.start();
      i_eat_master.wbyte({DEV ^ 7'h01, 1'b0}, a);
      check(a, 1'b0);
      i_eat_master.stop();
      i_eat_master.start();
      i_eat_master.wbyte({DEV, 1'b0}, a);
      i_eat_master.wbyte(8'hAA, a);
      check(a, 1'b0);
      i_eat_master.stop();
      // Reset in mid-run refills the array
      @(negedge clk);
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      for (int i = 0; i < 256; i++) exp_mem[i] = eat_pkg::MEM_RESET;
      repeat (2) @(negedge clk);
      check(sda_oe, 1'b0);
      check(prog_busy, 1'b0);
      read_run(8'h00, 2);
      report_and_stop();
   end
endmodule : eat_tb_top
